// ### hw/timer_pair.sv
// Two 16-bit timer/counters with external interrupt flags, Wishbone slave
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_map.svh"

module timer_pair
    import timer_pair_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // External pins
    input  wire logic        extIrqPinZero,
    input  wire logic        extIrqPinOne,
    input  wire logic        countPinZero,
    input  wire logic        countPinOne,
    // Interrupt controller handshake and core speed mode
    input  wire logic        vectorTimerZero,
    input  wire logic        vectorTimerOne,
    input  wire logic        vectorExtZero,
    input  wire logic        vectorExtOne,
    input  wire logic        doubleSpeedMode,
    // Requests toward interrupt controller and serial port
    output logic             irqTimerZero,
    output logic             irqTimerOne,
    output logic             irqExtZero,
    output logic             irqExtOne,
    output logic             baudTick
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [7:0]  control_q;
    logic [7:0]  modeReg_q;
    logic [1:0]  clkDouble_q;
    count_pair_t cnt0_q;
    count_pair_t cnt1_q;
    logic [`DIV_CNT_W-1:0] pre0_q;
    logic [`DIV_CNT_W-1:0] pre1_q;
    logic [`DIV_CNT_W-1:0] per0_q;
    logic [`DIV_CNT_W-1:0] per1_q;
    logic        tpin0_q;
    logic        tpin1_q;
    logic        ipin0_q;
    logic        ipin1_q;
    logic        ovf0, ovf1;

    mode_field_t field0, field1;
    timer_mode_t mode0, mode1;
    logic        wbReq, wbWrite, wbHit;
    logic [7:0]  wrByte;

    assign field0 = mode_field_t'(modeReg_q[3:0]);
    assign field1 = mode_field_t'(modeReg_q[7:4]);
    assign mode0  = timer_mode_t'(field0.mode);
    assign mode1  = timer_mode_t'(field1.mode);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Divider period for the timer clock seen in system cycles
    // The double bit or the standard core mode gives half speed, else full speed
    function automatic logic [`DIV_CNT_W-1:0] div_last(input logic dbl, input logic x2);
        if (dbl || !x2) begin
            div_last = `DIV_CNT_W'(`FAST_DIV - 1);
        end else begin
            div_last = `DIV_CNT_W'(0);
        end
    endfunction : div_last

    // Gate term: run bit, optionally qualified by the interrupt pin
    function automatic logic gate_ok(input logic run, input logic gate, input logic pin);
        gate_ok = run && (!gate || pin);
    endfunction : gate_ok

    // ------------------------------------------------------------------------
    // Timer clock and peripheral-cycle strobes
    // ------------------------------------------------------------------------
    logic tick0, tick1, per0, per1;
    assign tick0 = (pre0_q == div_last(clkDouble_q[0], doubleSpeedMode));
    assign tick1 = (pre1_q == div_last(clkDouble_q[1], doubleSpeedMode));
    assign per0  = tick0 && (per0_q == `DIV_CNT_W'(`PERIPH_DIV - 1));
    assign per1  = tick1 && (per1_q == `DIV_CNT_W'(`PERIPH_DIV - 1));

    // Prescalers: timer clock then divide by six
    // The six-count moves only on a timer-clock tick, so a new clock
    // selection takes effect at the next tick without a short period
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre0_q <= '0;
            pre1_q <= '0;
            per0_q <= '0;
            per1_q <= '0;
        end else begin
            pre0_q <= tick0 ? '0 : pre0_q + 1'b1;
            pre1_q <= tick1 ? '0 : pre1_q + 1'b1;
            if (tick0) begin
                per0_q <= per0 ? '0 : per0_q + 1'b1;
            end
            if (tick1) begin
                per1_q <= per1 ? '0 : per1_q + 1'b1;
            end
        end
    end

    // Pin samples once per peripheral cycle; falling pair is one count
    // A level shorter than one peripheral cycle may never be sampled,
    // so the far side must hold each level for a full cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tpin0_q <= 1'b0;
            tpin1_q <= 1'b0;
        end else begin
            if (per0) begin
                tpin0_q <= countPinZero;
            end
            if (per1) begin
                tpin1_q <= countPinOne;
            end
        end
    end

    // Input events per timer, after gating
    // In split mode the low byte keeps timer 0's controls and the high byte
    // borrows timer 1's run bit; timer 1 stays under that same run bit, so
    // software parks it through mode 3 when it must be stopped
    logic ev0, ev1, evHigh0;
    logic src0, src1;
    assign src0 = field0.source ? (per0 && tpin0_q && !countPinZero) : per0;
    assign src1 = field1.source ? (per1 && tpin1_q && !countPinOne)  : per1;
    assign ev0  = src0 && gate_ok(control_q[`CTL_RUN0], field0.gate, extIrqPinZero);
    assign ev1  = src1 && gate_ok(control_q[`CTL_RUN1], field1.gate, extIrqPinOne)
                  && (mode1 != MODE_SPLIT);
    assign evHigh0 = (mode0 == MODE_SPLIT) && per0 && control_q[`CTL_RUN1];

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    assign wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wbHit   = (wb_adr_i >= `ADDR_CONTROL) && (wb_adr_i <= `ADDR_CLOCK_CFG);
    assign wbWrite = wbReq && wbHit && wb_we_i && wb_sel_i[0];
    assign wrByte  = wb_dat_i[7:0];

    // Only byte lane 0 carries data; a write with that lane off is still
    // acked but changes nothing, so every access answers in the same time
    // Write strobe of one register, shared by every register process
    function automatic logic wr_hit(input logic wr, input logic [7:0] adr, input logic [7:0] target);
        wr_hit = wr && (adr == target);
    endfunction : wr_hit

    logic wrControl, wrMode, wrClock, wrLow0, wrLow1, wrHigh0, wrHigh1;
    assign wrControl = wr_hit(wbWrite, wb_adr_i, `ADDR_CONTROL);
    assign wrMode    = wr_hit(wbWrite, wb_adr_i, `ADDR_MODE);
    assign wrClock   = wr_hit(wbWrite, wb_adr_i, `ADDR_CLOCK_CFG);
    assign wrLow0    = wr_hit(wbWrite, wb_adr_i, `ADDR_LOW_ZERO);
    assign wrLow1    = wr_hit(wbWrite, wb_adr_i, `ADDR_LOW_ONE);
    assign wrHigh0   = wr_hit(wbWrite, wb_adr_i, `ADDR_HIGH_ZERO);
    assign wrHigh1   = wr_hit(wbWrite, wb_adr_i, `ADDR_HIGH_ONE);

    // ------------------------------------------------------------------------
    // Counting and overflow per mode
    // ------------------------------------------------------------------------
    // One counter body serves both timers; split high byte handled by caller
    // Bit 16 of the result is the overflow of whichever count is active
    function automatic logic [16:0] step(input count_pair_t c, input timer_mode_t m, input logic ev);
        logic [5:0] p;
        logic [8:0] h;
        logic [8:0] l;
        logic [16:0] w;
        step = {1'b0, c};
        p = {1'b0, c.low[4:0]} + 6'h01;
        h = {1'b0, c.high} + 9'h001;
        l = {1'b0, c.low} + 9'h001;
        w = {1'b0, c} + 17'h00001;
        if (ev) begin
            case (m)
                MODE_PRESCALE: begin
                    if (p[5]) begin
                        step = {h[8], h[7:0], c.low[7:5], 5'h00};
                    end else begin
                        step = {1'b0, c.high, c.low[7:5], p[4:0]};
                    end
                end
                MODE_WIDE:   step = w;
                MODE_RELOAD: step = l[8] ? {1'b1, c.high, c.high}
                                         : {1'b0, c.high, l[7:0]};
                MODE_SPLIT:  step = {l[8], c.high, l[7:0]};
                default:     step = {1'b0, c};
            endcase
        end
    endfunction : step

    logic [16:0] nx0, nx1;
    logic [8:0]  hi0;
    assign nx0  = step(cnt0_q, mode0, ev0);
    assign nx1  = step(cnt1_q, mode1, ev1);
    assign hi0  = {1'b0, cnt0_q.high} + 9'h001;
    assign ovf0 = nx0[16];
    assign ovf1 = nx1[16] || (evHigh0 && hi0[8]);

    // Count bytes: software write replaces the byte, otherwise hardware step
    // The write lands after the step in the same cycle, so a preset is never
    // lost to a concurrent increment; presetting a running timer is still
    // unsafe for the other byte, which keeps counting
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt0_q <= '0;
            cnt1_q <= '0;
        end else begin
            cnt0_q <= nx0[15:0];
            cnt1_q <= nx1[15:0];
            if (evHigh0) begin
                cnt0_q.high <= hi0[7:0];
            end
            if (wrLow0) begin
                cnt0_q.low <= wrByte;
            end
            if (wrHigh0) begin
                cnt0_q.high <= wrByte;
            end
            if (wrLow1) begin
                cnt1_q.low <= wrByte;
            end
            if (wrHigh1) begin
                cnt1_q.high <= wrByte;
            end
        end
    end

    // ------------------------------------------------------------------------
    // External interrupt detection
    // ------------------------------------------------------------------------
    // Pin history resets to the idle high level, so no false falling edge
    // follows reset; a pin held low through reset raises no edge either,
    // only a level request, as reset leaves level mode chosen
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ipin0_q <= 1'b1;
            ipin1_q <= 1'b1;
        end else begin
            ipin0_q <= extIrqPinZero;
            ipin1_q <= extIrqPinOne;
        end
    end

    logic ext0Set, ext1Set;
    assign ext0Set = control_q[`CTL_TYPE0] ? (ipin0_q && !extIrqPinZero) : !extIrqPinZero;
    assign ext1Set = control_q[`CTL_TYPE1] ? (ipin1_q && !extIrqPinOne)  : !extIrqPinOne;

    // ------------------------------------------------------------------------
    // Control register: hardware sets win over software writes and vectoring
    // ------------------------------------------------------------------------
    logic [7:0] control_d;

    // Next control value; the hardware sets come last so that they win
    // over a software write or a vector clear in the same cycle
    always_comb begin
        control_d = control_q;
        if (wrControl) begin
            control_d = wrByte;
        end
        if (vectorTimerZero) begin
            control_d[`CTL_OVF0] = 1'b0;
        end
        if (vectorTimerOne) begin
            control_d[`CTL_OVF1] = 1'b0;
        end
        if (vectorExtZero && control_q[`CTL_TYPE0]) begin
            control_d[`CTL_EXT0] = 1'b0;
        end
        if (vectorExtOne && control_q[`CTL_TYPE1]) begin
            control_d[`CTL_EXT1] = 1'b0;
        end
        if (!control_q[`CTL_TYPE0]) begin
            control_d[`CTL_EXT0] = ext0Set;  // Level mode follows the pin
        end
        if (!control_q[`CTL_TYPE1]) begin
            control_d[`CTL_EXT1] = ext1Set;
        end
        control_d[`CTL_OVF0] = control_d[`CTL_OVF0] | ovf0;
        control_d[`CTL_OVF1] = control_d[`CTL_OVF1] | ovf1;
        control_d[`CTL_EXT0] = control_d[`CTL_EXT0] | ext0Set;
        control_d[`CTL_EXT1] = control_d[`CTL_EXT1] | ext1Set;
    end

    // Control register stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            control_q <= `RESET_BYTE;
        end else begin
            control_q <= control_d;
        end
    end

    // Mode and clock-config registers, software owned
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            modeReg_q   <= `RESET_BYTE;
            clkDouble_q <= 2'h0;
        end else begin
            if (wrMode) begin
                modeReg_q <= wrByte;
            end
            if (wrClock) begin
                clkDouble_q <= wrByte[1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer: one-cycle ack, error for unmapped addresses
    // ------------------------------------------------------------------------
    // Answers are registered: one wait state on every access, traded for a
    // short path from the decoder; a held request is not taken again while
    // its answer stands
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wbReq && wbHit;
            wb_err_o <= wbReq && !wbHit;
            wb_dat_o <= '0;
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i)
                    `ADDR_CONTROL:   wb_dat_o <= {24'h000000, control_q};
                    `ADDR_MODE:      wb_dat_o <= {24'h000000, modeReg_q};
                    `ADDR_LOW_ZERO:  wb_dat_o <= {24'h000000, cnt0_q.low};
                    `ADDR_LOW_ONE:   wb_dat_o <= {24'h000000, cnt1_q.low};
                    `ADDR_HIGH_ZERO: wb_dat_o <= {24'h000000, cnt0_q.high};
                    `ADDR_HIGH_ONE:  wb_dat_o <= {24'h000000, cnt1_q.high};
                    `ADDR_CLOCK_CFG: wb_dat_o <= {30'h00000000, clkDouble_q};
                    default:         wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registered request outputs
    // ------------------------------------------------------------------------
    // Request outputs trail the control register by one cycle, so a vector
    // pulse must be judged against the register, not against these copies;
    // the baud tick is timer 1's own overflow only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqTimerZero <= 1'b0;
            irqTimerOne  <= 1'b0;
            irqExtZero   <= 1'b0;
            irqExtOne    <= 1'b0;
            baudTick     <= 1'b0;
        end else begin
            irqTimerZero <= control_q[`CTL_OVF0];
            irqTimerOne  <= control_q[`CTL_OVF1];
            irqExtZero   <= control_q[`CTL_EXT0];
            irqExtOne    <= control_q[`CTL_EXT1];
            baudTick     <= nx1[16];
        end
    end

endmodule : timer_pair
`default_nettype wire

// ### hw/timer_pair_map.svh
// Register map, field positions, reset values and timing counts of the timer pair
`ifndef TIMER_PAIR_MAP_SVH
`define TIMER_PAIR_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses (word index is the printed offset)
// ----------------------------------------------------------------------------
`define ADDR_CONTROL    8'h88
`define ADDR_MODE       8'h89
`define ADDR_LOW_ZERO   8'h8A
`define ADDR_LOW_ONE    8'h8B
`define ADDR_HIGH_ZERO  8'h8C
`define ADDR_HIGH_ONE   8'h8D
`define ADDR_CLOCK_CFG  8'h8E

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTL_TYPE0  0
`define CTL_EXT0   1
`define CTL_TYPE1  2
`define CTL_EXT1   3
`define CTL_RUN0   4
`define CTL_OVF0   5
`define CTL_RUN1   6
`define CTL_OVF1   7

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RESET_BYTE     8'h00
`define PERIPH_DIV     6
`define DIV_CNT_W      3
`define FAST_DIV       2
`define STD_DIV        4

`endif

// ### hw/timer_pair_pkg.sv
// Types shared by the timer pair
package timer_pair_pkg;

    typedef enum logic [1:0] {
        MODE_PRESCALE,
        MODE_WIDE,
        MODE_RELOAD,
        MODE_SPLIT
    } timer_mode_t;

    typedef struct packed {
        logic       gate;
        logic       source;
        logic [1:0] mode;
    } mode_field_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } count_pair_t;

endpackage : timer_pair_pkg

// ### bench/pin_partner.sv
// Far-side model of the count and external interrupt pins
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Commands from the bench
    input  wire logic       go,
    input  wire logic       pinSel,
    input  wire logic [3:0] falls,
    input  wire logic [1:0] extLvl,
    // Pins toward the timer pair, and busy back to the bench
    output logic            countPinZero,
    output logic            countPinOne,
    output logic            extIrqPinZero,
    output logic            extIrqPinOne,
    output logic            busy
);
    logic [4:0] phaseQ;
    logic [4:0] holdQ;
    logic       selQ;

    // Each level stays 24 clocks, two sampling periods, so no fall is missed
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phaseQ <= 5'h00;
            holdQ  <= 5'h00;
            selQ   <= 1'b0;
        end else if (go && phaseQ == 5'h00) begin
            phaseQ <= {falls, 1'b0};
            holdQ  <= 5'h00;
            selQ   <= pinSel;
        end else if (phaseQ != 5'h00) begin
            holdQ <= (holdQ == 5'h17) ? 5'h00 : holdQ + 5'h01;
            if (holdQ == 5'h17) begin
                phaseQ <= phaseQ - 5'h01;
            end
        end
    end

    // Count pins idle high; odd phases are the low half of a pulse
    assign busy          = phaseQ != 5'h00;
    assign countPinZero  = selQ | ~phaseQ[0];
    assign countPinOne   = ~selQ | ~phaseQ[0];
    // Gate and interrupt pins follow the bench's level request
    assign extIrqPinZero = extLvl[0];
    assign extIrqPinOne  = extLvl[1];
endmodule : pin_partner
`default_nettype wire

// ### bench/timer_pair_asserts.sv
// Port checks of the timer pair: bus answers and baud ticks
`timescale 1ns/100ps
`default_nettype none
module timer_pair_asserts (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        irqTimerOne,
    input wire logic        baudTick
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic take;
    logic mapped;
    // A request counts only while no answer is outstanding
    assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped = wb_adr_i >= 8'h88 && wb_adr_i <= 8'h8E;

    ack_mapped_a: assert property (take && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked next cycle");
    err_unmapped_a: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_pulse_a: assert property (wb_err_o |=> !wb_err_o)
        else $error("err longer than one cycle");
    no_idle_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    ack_err_excl_a: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    // Overflow sets the flag seen at the interrupt output
    baud_flag_a: assert property (baudTick |-> ##[0:2] irqTimerOne)
        else $error("baud tick without overflow flag");
    // An increment needs at least six timer clocks
    baud_space_a: assert property (baudTick |=> !baudTick [*5])
        else $error("baud ticks too close");
endmodule : timer_pair_asserts

bind timer_pair timer_pair_asserts u_chk (
    .sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .irqTimerOne, .baudTick
);
`default_nettype wire

// ### bench/timer_pair_tb_top.sv
// Self-checking bench of the timer pair
`timescale 1ns/100ps
`default_nettype none
module timer_pair_tb_top;
    logic        sys_clk, nrst, cyc, stb, we, dsm, go, psel, vt0, vt1, ve0;
    logic        ack, err, irqT0, irqT1, irqE0, irqE1, baud, busy, cp0, cp1, ep0, ep1;
    logic [7:0]  adr, dat, r;
    logic [3:0]  falls;
    logic [1:0]  extLvl;
    logic [31:0] rdat, rs;
    logic [8:0]  qe;
    logic [8:0]  expQ[$];
    int          n_errors, total_checks, t, n;
    wire  [3:0]  irqs = {irqE1, irqE0, irqT1, irqT0};

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    timer_pair u_dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, dat}), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .extIrqPinZero(ep0), .extIrqPinOne(ep1), .countPinZero(cp0), .countPinOne(cp1),
        .vectorTimerZero(vt0), .vectorTimerOne(vt1), .vectorExtZero(ve0), .vectorExtOne(1'b0),
        .doubleSpeedMode(dsm), .irqTimerZero(irqT0), .irqTimerOne(irqT1), .irqExtZero(irqE0),
        .irqExtOne(irqE1), .baudTick(baud));
    pin_partner u_pins (.sys_clk(sys_clk), .nrst(nrst), .go(go), .pinSel(psel), .falls(falls),
        .extLvl(extLvl), .countPinZero(cp0), .countPinOne(cp1), .extIrqPinZero(ep0),
        .extIrqPinOne(ep1), .busy(busy));

    // ------------
    // Tasks
    // ------------
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle: hold everything until ack or err is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while ((ack | err) !== 1'b1 && k < 40);
        if (k >= 40) chk(9'h000, 9'h1FF);
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        expQ.push_back(e);
        wb(a, 1'b0, 8'h00);
    endtask : rd
    // Bounded wait for one interrupt output to reach a level
    task automatic wt(input int k, input logic v, input int lim);
        t = 0;
        while (irqs[k] !== v && t < lim) begin
            @(posedge sys_clk);
            t++;
        end
        if (t >= lim) chk(9'h000, 9'h1FF);
    endtask : wt
    task automatic pins(input logic s, input logic [3:0] c);
        int k;
        @(posedge sys_clk);
        go <= 1'b1; psel <= s; falls <= c;
        @(posedge sys_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (busy !== 1'b0 && k < 500);
        repeat (40) @(posedge sys_clk);
    endtask : pins
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    // Result watcher: oldest note against each read answer or error
    always @(posedge sys_clk) begin
        if ((ack & ~we) === 1'b1 || err === 1'b1) begin
            if (expQ.size() == 0) chk(9'h000, 9'h1FF);
            else begin
                qe = expQ.pop_front();
                chk(qe[8] ? {err, 8'h00} : {err, rdat[7:0]}, qe);
            end
        end
    end

    initial begin
        #400000;
        n_errors++;
        test_done;
    end

    initial begin
        nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 8'h00; dsm = 1'b0;
        go = 1'b0; psel = 1'b0; falls = 4'h0; extLvl = 2'b11; vt0 = 1'b0; vt1 = 1'b0; ve0 = 1'b0;
        rs = 32'hA38D;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        // Reset values, then an unmapped place
        for (int i = 0; i < 7; i++) rd(8'h88 + 8'(i), 9'h000);
        rd(8'h90, 9'h100);
        // 16-bit counter with carry into the high byte
        n = int'(rnd() % 4) + 2;
        wb(8'h89, 1'b1, 8'h05); wb(8'h8C, 1'b1, 8'h12); wb(8'h8A, 1'b1, 8'hFE); wb(8'h88, 1'b1, 8'h10);
        pins(1'b0, 4'(n));
        rd(8'h8A, {1'b0, 8'hFE + 8'(n)});
        rd(8'h8C, 9'h013);
        // Gate set with the pin low freezes the count
        wb(8'h88, 1'b1, 8'h00); wb(8'h89, 1'b1, 8'h0D); extLvl <= 2'b10; wb(8'h88, 1'b1, 8'h10);
        pins(1'b0, 4'h2);
        extLvl <= 2'b11;
        rd(8'h8A, {1'b0, 8'hFE + 8'(n)});
        // 13-bit mode: prescaler rollover bumps the high byte
        wb(8'h88, 1'b1, 8'h00); wb(8'h89, 1'b1, 8'h04); wb(8'h8C, 1'b1, 8'h40); wb(8'h8A, 1'b1, 8'hFF);
        wb(8'h88, 1'b1, 8'h10);
        pins(1'b0, 4'h1);
        rd(8'h8C, 9'h041);
        // Timer 1 auto-reload counter with a random reload value
        r = {1'b0, 7'(rnd())};
        wb(8'h88, 1'b1, 8'h00); wb(8'h89, 1'b1, 8'h60); wb(8'h8D, 1'b1, r); wb(8'h8B, 1'b1, 8'hFE);
        wb(8'h88, 1'b1, 8'h40);
        pins(1'b1, 4'h3);
        rd(8'h8B, {1'b0, r + 8'h01});
        rd(8'h8D, {1'b0, r});
        rd(8'h88, 9'h0C0);
        // New reload value written while running
        wb(8'h88, 1'b1, 8'h00); wb(8'h8B, 1'b1, 8'hFE); wb(8'h88, 1'b1, 8'h40); wb(8'h8D, 1'b1, 8'h80);
        pins(1'b1, 4'h2);
        rd(8'h8B, 9'h080);
        // Timer 1 mode 3 holds even with its run bit set
        wb(8'h88, 1'b1, 8'h00); wb(8'h89, 1'b1, 8'h70); wb(8'h88, 1'b1, 8'h40);
        pins(1'b1, 4'h3);
        rd(8'h8B, 9'h080);
        // Timer function: 16 increments of 12 clocks each
        wb(8'h88, 1'b1, 8'h00); wb(8'h89, 1'b1, 8'h01); wb(8'h8C, 1'b1, 8'hFF); wb(8'h8A, 1'b1, 8'hF0);
        wb(8'h88, 1'b1, 8'h10);
        wt(0, 1'b1, 400);
        chk({8'h00, t >= 175 && t <= 210}, 9'h001);
        wb(8'h88, 1'b1, 8'h20);
        vt0 <= 1'b1;
        @(posedge sys_clk);
        vt0 <= 1'b0;
        rd(8'h88, 9'h000);
        // Split mode: high byte runs on run1 and sets flag one
        wb(8'h88, 1'b1, 8'h00); dsm <= 1'b1; wb(8'h89, 1'b1, 8'h03); wb(8'h8C, 1'b1, 8'hFE);
        wb(8'h88, 1'b1, 8'h40);
        wt(1, 1'b1, 100);
        chk({8'h00, t >= 6 && t <= 20}, 9'h001);
        rd(8'h88, 9'h0C0);
        vt1 <= 1'b1;
        @(posedge sys_clk);
        vt1 <= 1'b0;
        rd(8'h88, 9'h040);
        // Falling edge on pin zero, sticky until serviced
        wb(8'h88, 1'b1, 8'h01);
        extLvl <= 2'b10;
        wt(2, 1'b1, 40);
        extLvl <= 2'b11;
        rd(8'h88, 9'h003);
        ve0 <= 1'b1;
        @(posedge sys_clk);
        ve0 <= 1'b0;
        rd(8'h88, 9'h001);
        // Low level on pin one, flag follows the pin
        extLvl <= 2'b01;
        wt(3, 1'b1, 40);
        rd(8'h88, 9'h009);
        extLvl <= 2'b11;
        wt(3, 1'b0, 40);
        rd(8'h88, 9'h001);
        test_done;
    end
endmodule : timer_pair_tb_top
`default_nettype wire
